/* src/pmrom_host.sv */
// Host controller that reads a page mode mask ROM through its pins
`timescale 1ns/100ps
// Functional notes
// - Address settles within skew while selected
// - No skew limit outside chip select
// - Chip select high at power up
// - Chip select high 200 ns before reads
// - Other pins free during power-up wait
module pmrom_host #(
  parameter logic [1:0] GATE_OPTION = pmrom_pkg::GATE_LOW,
  parameter bit LARGE_PAGE = 1'b0
) (
  input wire logic I_MCLK,
  input wire logic I_SRST,
  input wire logic i_req,
  input wire logic i_word,
  input wire logic [pmrom_pkg::ADDR_W:0] i_addr,
  output logic o_ready,
  output logic o_rvalid,
  output logic [pmrom_pkg::DATA_W-1:0] o_rdata,
  output logic [pmrom_pkg::ADDR_W-1:0] o_rom_addr,
  output logic o_rom_cs_n,
  output logic o_rom_gate,
  output logic o_rom_word,
  output logic o_rom_d15_out,
  output logic o_rom_d15_oe,
  input wire logic [pmrom_pkg::DATA_W-2:0] i_rom_data,
  input wire logic i_rom_d15_in
);
  localparam int PAGE_BITS = LARGE_PAGE ? pmrom_pkg::PAGE_BITS_LARGE
                                        : pmrom_pkg::PAGE_BITS_SMALL;

  pmrom_tmr_if tmr ();

  pmrom_timer u_timer (
    .i_clk(I_MCLK),
    .i_rst(I_SRST),
    .tmr(tmr)
  );

  pmrom_pkg::pmrom_state_t state_ff, nxt_state;
  logic ready_ff, nxt_ready;
  logic rvalid_ff, nxt_rvalid;
  logic [pmrom_pkg::DATA_W-1:0] rdata_ff, nxt_rdata;
  logic [pmrom_pkg::ADDR_W-1:0] addr_ff, nxt_addr;
  logic cs_n_ff, nxt_cs_n;
  logic gate_on_ff, nxt_gate_on;
  logic gate_ff, nxt_gate;
  logic word_ff, nxt_word;
  logic d15_ff, nxt_d15;
  logic d15_oe_ff, nxt_d15_oe;
  logic page_ok_ff, nxt_page_ok;
  logic pwr_load_ff, nxt_pwr_load;
  logic same_page;
  logic [pmrom_pkg::ADDR_W:0] last_addr;
  logic [pmrom_pkg::DATA_W-1:0] sampled;

  // ****************************************************************
  // Page match and data sampling
  // ****************************************************************
  // In byte mode the request lsb goes out on the shared pin
  assign last_addr = {addr_ff, d15_ff};
  // Page field is the byte lsb plus PAGE_BITS address bits above it
  assign same_page = page_ok_ff && (i_word == word_ff) &&
    (i_addr[pmrom_pkg::ADDR_W:PAGE_BITS+1] ==
     last_addr[pmrom_pkg::ADDR_W:PAGE_BITS+1]);

  always_comb
  begin
    if (word_ff)
      sampled = {i_rom_d15_in, i_rom_data};
    else
      sampled = {8'h00, i_rom_data[pmrom_pkg::BYTE_W-1:0]};
  end

  // Gate level that enables the outputs for this option
  function automatic logic gate_level(input logic on);
    case (GATE_OPTION)
      pmrom_pkg::GATE_LOW: gate_level = !on;
      pmrom_pkg::GATE_HIGH: gate_level = on;
      default: gate_level = 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb
  begin
    nxt_state = state_ff;
    nxt_ready = 1'b0;
    nxt_rvalid = 1'b0;
    nxt_rdata = rdata_ff;
    nxt_addr = addr_ff;
    nxt_cs_n = cs_n_ff;
    nxt_gate_on = gate_on_ff;
    nxt_word = word_ff;
    nxt_d15 = d15_ff;
    nxt_d15_oe = d15_oe_ff;
    nxt_page_ok = page_ok_ff;
    tmr.load = 1'b0;
    tmr.count = pmrom_pkg::CNT_ZERO;
    case (state_ff)
      pmrom_pkg::PMR_POWERUP:
      begin
        nxt_cs_n = 1'b1;
        if (pwr_load_ff)
        begin
          tmr.load = 1'b1;
          tmr.count = pmrom_pkg::POWERUP_CYC;
        end
        else if (tmr.expired)
        begin
          nxt_state = pmrom_pkg::PMR_IDLE;
          nxt_ready = 1'b1;
        end
      end
      pmrom_pkg::PMR_IDLE:
      begin
        nxt_ready = 1'b1;
        if (i_req)
        begin
          nxt_ready = 1'b0;
          tmr.load = 1'b1;
          nxt_addr = i_addr[pmrom_pkg::ADDR_W:1];
          nxt_d15 = i_addr[0];
          nxt_d15_oe = !i_word;
          nxt_word = i_word;
          nxt_cs_n = 1'b0;
          nxt_gate_on = 1'b1;
          if (same_page)
            tmr.count = pmrom_pkg::PAGE_CYC;
          else if (i_word != word_ff)
            tmr.count = pmrom_pkg::WIDTH_CYC;
          else if (cs_n_ff)
            tmr.count = pmrom_pkg::ACCESS_CYC;
          else if (!gate_on_ff)
            tmr.count = pmrom_pkg::GATE_CYC;
          else
            tmr.count = pmrom_pkg::ACCESS_CYC;
          nxt_state = pmrom_pkg::PMR_WAIT;
        end
      end
      pmrom_pkg::PMR_WAIT:
      begin
        if (tmr.expired)
        begin
          nxt_rdata = sampled;
          nxt_rvalid = 1'b1;
          nxt_page_ok = 1'b1;
          nxt_state = pmrom_pkg::PMR_DONE;
        end
      end
      pmrom_pkg::PMR_DONE:
      begin
        // Stay selected for page hits; otherwise release the bus
        if (i_req && same_page)
        begin
          tmr.load = 1'b1;
          tmr.count = pmrom_pkg::PAGE_CYC;
          nxt_d15 = i_addr[0];
          nxt_addr = i_addr[pmrom_pkg::ADDR_W:1];
          nxt_state = pmrom_pkg::PMR_WAIT;
        end
        else
        begin
          nxt_cs_n = 1'b1;
          nxt_gate_on = 1'b0;
          nxt_page_ok = 1'b0;
          tmr.load = 1'b1;
          tmr.count = pmrom_pkg::FLOAT_CYC;
          nxt_state = pmrom_pkg::PMR_RELEASE;
        end
      end
      pmrom_pkg::PMR_RELEASE:
      begin
        if (tmr.expired)
        begin
          nxt_state = pmrom_pkg::PMR_IDLE;
          nxt_ready = 1'b1;
        end
      end
      default:
        nxt_state = pmrom_pkg::PMR_IDLE;
    endcase
    nxt_gate = gate_level(nxt_gate_on);
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_SRST)
    begin
      state_ff <= pmrom_pkg::PMR_POWERUP;
      ready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 16'h0000;
      addr_ff <= 21'h000000;
      cs_n_ff <= 1'b1;
      gate_on_ff <= 1'b0;
      gate_ff <= gate_level(1'b0);
      word_ff <= 1'b1;
      d15_ff <= 1'b0;
      d15_oe_ff <= 1'b0;
      page_ok_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      ready_ff <= nxt_ready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      addr_ff <= nxt_addr;
      cs_n_ff <= nxt_cs_n;
      gate_on_ff <= nxt_gate_on;
      gate_ff <= nxt_gate;
      word_ff <= nxt_word;
      d15_ff <= nxt_d15;
      d15_oe_ff <= nxt_d15_oe;
      page_ok_ff <= nxt_page_ok;
    end
  end

  // Power-up wait loads on the first cycle out of reset
  always_comb
  begin
    nxt_pwr_load = 1'b0;
  end
  always_ff @(posedge I_MCLK)
  begin
    if (I_SRST)
      pwr_load_ff <= 1'b1;
    else
      pwr_load_ff <= nxt_pwr_load;
  end

  assign o_ready = ready_ff;
  assign o_rvalid = rvalid_ff;
  assign o_rdata = rdata_ff;
  assign o_rom_addr = addr_ff;
  assign o_rom_cs_n = cs_n_ff;
  assign o_rom_gate = gate_ff;
  assign o_rom_word = word_ff;
  assign o_rom_d15_out = d15_ff;
  assign o_rom_d15_oe = d15_oe_ff;
endmodule

/* pkg/pmrom_pkg.sv */
// Package: constants and types for the page mode ROM read controller
package pmrom_pkg;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int CLK_PERIOD_NS = 20;
  // Access times, worst case over both supply ranges
  localparam int ACCESS_NS = 100;
  localparam int PAGE_ACCESS_NS = 25;
  localparam int GATE_ACCESS_NS = 25;
  localparam int FLOAT_NS = 25;
  localparam int WIDTH_SWITCH_NS = 100;
  localparam int SKEW_NS = 10;
  localparam int POWERUP_WAIT_NS = 200;
  localparam int CNT_W = 5;
  // Least times round up
  localparam logic [CNT_W-1:0] ACCESS_CYC =
    CNT_W'((ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] PAGE_CYC =
    CNT_W'((PAGE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] GATE_CYC =
    CNT_W'((GATE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] FLOAT_CYC =
    CNT_W'((FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] WIDTH_CYC =
    CNT_W'((WIDTH_SWITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] POWERUP_CYC =
    CNT_W'((POWERUP_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  // Gate polarity options
  localparam logic [1:0] GATE_LOW = 2'h0;
  localparam logic [1:0] GATE_HIGH = 2'h1;
  localparam logic [1:0] GATE_IGNORED = 2'h2;
  // Page address width above the byte lsb: small variant 2, large 3
  localparam int PAGE_BITS_SMALL = 2;
  localparam int PAGE_BITS_LARGE = 3;
  typedef enum logic [2:0] {
    PMR_POWERUP, PMR_IDLE, PMR_SETUP, PMR_WAIT, PMR_DONE, PMR_RELEASE
  } pmrom_state_t;
endpackage

/* pkg/pmrom_tmr_if.sv */
// Interface between the sequencer and its wait timer
`timescale 1ns/100ps
interface pmrom_tmr_if;
  logic load;
  logic [pmrom_pkg::CNT_W-1:0] count;
  logic expired;
  modport ctrl (output load, output count, input expired);
  modport timer (input load, input count, output expired);
endinterface

/* src/pmrom_timer.sv */
// Down counter that times the bus phases of a ROM access
`timescale 1ns/100ps
module pmrom_timer (
  input wire logic i_clk,
  input wire logic i_rst,
  pmrom_tmr_if.timer tmr
);
  logic [pmrom_pkg::CNT_W-1:0] cnt_ff;
  logic [pmrom_pkg::CNT_W-1:0] nxt_cnt;

  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (tmr.load)
      nxt_cnt = tmr.count;
    else if (cnt_ff != pmrom_pkg::CNT_ZERO)
      nxt_cnt = cnt_ff - pmrom_pkg::CNT_ONE;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      cnt_ff <= pmrom_pkg::CNT_ZERO;
    else
      cnt_ff <= nxt_cnt;
  end

  assign tmr.expired = !tmr.load && (cnt_ff == pmrom_pkg::CNT_ZERO);
endmodule

/* dv/pmrom_rom_model.sv */
// Behavioural page mode ROM as seen from its pins
`timescale 1ns/100ps
module pmrom_rom_model #(
  parameter logic [1:0] GATE_OPTION = 2'h0,
  parameter bit LARGE_PAGE = 1'b0
) (
  input wire logic [20:0] i_addr,
  input wire logic i_cs_n,
  input wire logic i_gate,
  input wire logic i_word,
  input wire logic i_lsb,
  output logic [14:0] o_data,
  output logic o_d15
);
  realtime t_ok = 0;
  realtime d;
  logic [21:0] kp = 22'h000000;
  logic [1:0] mp = 2'h0;
  logic [15:0] q;
  wire logic lsb = i_word ? 1'b0 : i_lsb;
  wire logic on = !i_cs_n &&
    (GATE_OPTION == 2'h2 || i_gate == GATE_OPTION[0]);
  initial {o_d15, o_data} = 16'h5555;
  // Earliest time at which the selected data is valid
  always @(i_addr, i_cs_n, i_word, lsb, i_gate)
  begin
    d = (({i_addr, lsb} >> (LARGE_PAGE ? 4 : 3)) != kp ||
      {i_cs_n, i_word} != mp) ? 100 : 25;
    if ($realtime + d > t_ok)
      t_ok = $realtime + d;
    kp = {i_addr, lsb} >> (LARGE_PAGE ? 4 : 3);
    mp = {i_cs_n, i_word};
  end
  // Undriven lines toggle so stale data never looks valid
  always #1
  begin
    q = i_addr[15:0] ^ {11'h2d3, i_addr[20:16]};
    if (on && $realtime >= t_ok)
    begin
      o_data[7:0] = lsb ? q[15:8] : q[7:0];
      o_data[14:8] = i_word ? q[14:8] : ~o_data[14:8];
      o_d15 = i_word ? q[15] : ~o_d15;
    end
    else
      {o_d15, o_data} = ~{o_d15, o_data};
  end
endmodule

/* dv/pmrom_host_asserts.sv */
// Pin timing checker for the ROM host controller
`timescale 1ns/100ps
module pmrom_host_asserts #(
  parameter logic [1:0] GATE_OPTION = 2'h0
) (
  input wire logic I_MCLK,
  input wire logic I_SRST,
  input wire logic o_ready,
  input wire logic o_rvalid,
  input wire logic [pmrom_pkg::ADDR_W-1:0] o_rom_addr,
  input wire logic o_rom_cs_n,
  input wire logic o_rom_gate,
  input wire logic o_rom_word,
  input wire logic o_rom_d15_oe
);
  logic [3:0] pw_ff;
  logic [3:0] nxt_pw;
  always_comb nxt_pw = (pw_ff == 4'hf) ? pw_ff : pw_ff + 4'h1;
  always_ff @(posedge I_MCLK)
  begin
    if (I_SRST)
      pw_ff <= 4'h0;
    else
      pw_ff <= nxt_pw;
  end
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_SRST);
  a_cs_reset_high: assert property ($fell(I_SRST) |-> o_rom_cs_n)
    else $error("select low at reset release");
  a_powerup_wait: assert property (!o_rom_cs_n |-> pw_ff >= 4'ha)
    else $error("select low before power-up wait");
  a_no_early_data: assert property ($fell(o_rom_cs_n) |-> !o_rvalid[*5])
    else $error("data taken before access time");
  a_read_bounded: assert property ($fell(o_rom_cs_n) |-> ##[1:12] o_rvalid)
    else $error("read never completed");
  a_addr_held: assert property (!o_rom_cs_n && !$past(o_rom_cs_n) &&
    !$past(o_rvalid) |-> $stable(o_rom_addr) && $stable(o_rom_word))
    else $error("address moved during access");
  a_float_gap: assert property ($rose(o_rom_cs_n) |-> o_rom_cs_n[*2])
    else $error("reselected before float time");
  a_gate_idle: assert property
    (o_rom_cs_n |-> o_rom_gate == (GATE_OPTION == 2'h0))
    else $error("gate active while deselected");
  a_gate_read: assert property (o_rvalid |-> !o_rom_cs_n &&
    o_rom_gate == (GATE_OPTION == 2'h1))
    else $error("data returned without active gate");
  a_shared_pin_dir: assert property
    (!o_rom_cs_n |-> o_rom_d15_oe == !o_rom_word)
    else $error("shared pin direction wrong");
  a_ready_bus_free: assert property (o_ready |-> o_rom_cs_n)
    else $error("ready while still selected");
  a_ready_after_wait: assert property (o_ready |-> pw_ff >= 4'ha)
    else $error("ready before power-up wait");
endmodule
bind pmrom_host pmrom_host_asserts #(.GATE_OPTION(GATE_OPTION))
  pmrom_host_asserts_i (.I_MCLK, .I_SRST, .o_ready, .o_rvalid, .o_rom_addr,
  .o_rom_cs_n, .o_rom_gate, .o_rom_word, .o_rom_d15_oe);

/* dv/test_pmrom_host.sv */
// Self-checking bench for the ROM host controller
`timescale 1ns/100ps
module test_pmrom_host;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] req = 3'h0;
  logic [2:0] word = 3'h0;
  logic [21:0] addr [3] = '{default: 22'h000000};
  wire logic [2:0] rdy, rv, cs_n, gt, wd, oe, d15o, md15;
  wire logic [15:0] rdat [3];
  wire logic [20:0] ra [3];
  wire logic [14:0] dq [3];
  int n_errors = 0;
  int cmp_count = 0;
  int seed = 32'hf5cf08d7;
  always #10 clk = ~clk;
  for (genvar g = 0; g < 3; g++)
  begin : gen_dut
    wire logic d15 = oe[g] ? d15o[g] : md15[g];
    pmrom_host #(.GATE_OPTION(2'(g)), .LARGE_PAGE(g == 1)) pmrom_host_i (
      .I_MCLK(clk), .I_SRST(rst), .i_req(req[g]), .i_word(word[g]),
      .i_addr(addr[g]), .o_ready(rdy[g]), .o_rvalid(rv[g]),
      .o_rdata(rdat[g]), .o_rom_addr(ra[g]), .o_rom_cs_n(cs_n[g]),
      .o_rom_gate(gt[g]), .o_rom_word(wd[g]), .o_rom_d15_out(d15o[g]),
      .o_rom_d15_oe(oe[g]), .i_rom_data(dq[g]), .i_rom_d15_in(d15));
    pmrom_rom_model #(.GATE_OPTION(2'(g)), .LARGE_PAGE(g == 1))
      pmrom_rom_model_i (.i_addr(ra[g]), .i_cs_n(cs_n[g]), .i_gate(gt[g]),
      .i_word(wd[g]), .i_lsb(d15), .o_data(dq[g]), .o_d15(md15[g]));
  end
  function automatic logic [15:0] expv(logic w, logic [21:0] a);
    logic [15:0] q;
    q = a[16:1] ^ {11'h2d3, a[21:17]};
    return w ? q : {8'h00, a[0] ? q[15:8] : q[7:0]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One full access, then np reads inside the same page
  task automatic burst(input int g, input logic w, input logic [21:0] a,
    input int np);
    int n;
    logic [21:0] m;
    m = (g == 1) ? 22'h00000f : 22'h000007;
    n = 0;
    while (rdy[g] !== 1'b1 && n < 40)
    begin
      n++;
      @(negedge clk);
    end
    chk(16'(rdy[g]), 16'h0001);
    for (int k = 0; k <= np; k++)
    begin
      req[g] = 1'b1;
      word[g] = w;
      addr[g] = a;
      n = 0;
      // Request stays up until the read returns
      do
      begin
        n++;
        @(negedge clk);
      end
      while (rv[g] !== 1'b1 && n < 20);
      chk(16'(rv[g]), 16'h0001);
      chk(rdat[g], expv(w, a));
      a = (a & ~m) | (22'($random(seed)) & m);
    end
    req[g] = 1'b0;
  endtask
  task test_done;
    $display("cmp_count=%0d n_errors=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    for (int g = 0; g < 3; g++)
    begin
      for (int t = 0; t < 6; t++)
        burst(g, 1'($random(seed)), t == 0 ? 22'h3fffff :
          22'($random(seed)), t % 4);
      $display("Test gate option %0d done", g);
    end
    test_done;
  end
  initial
  begin
    #400000;
    n_errors++;
    test_done;
  end
endmodule
